// file: logic/pvbf_defs.svh
// Constants of the preset, boot and fault record register bank.
// Assumes includers pull it in at file scope, ahead of their module.
// Operation
// - Select code 000 uses first preset register
// - Select code 101 uses sixth preset register
// - Select code 110 uses seventh preset register
// - Select code 111 uses eighth preset register
// - Boot pin level picks sixth, seventh, eighth
// - Sixteen-bit user revision word, no regulation effect
// - First record keeps previous power cycle faults
// - Writing zero clears record; host waits 5ms
// - Reserved record bits ignore writes, read zero
// - Bit 13 set on temperature pin fault
// - Bits 12:10 give sense fault location
// - Bits 9,8,7: input OV, UVLO, IO supply
// - Bit 6 set on power stage overtemperature
// - Rail 1 OV, UV, OC in 5,4,3
// - Rail 2 OV, UV, OC in 2,1,0
// - Second record holds phases one to four
// - Nibble codes: none, short, limit, hot, ground
// - Third record holds phases five, six, seven
`ifndef PVBF_DEFS_SVH
`define PVBF_DEFS_SVH

// Command codes
`define PVBF_CMD_PRESET5      8'h86
`define PVBF_CMD_PRESET6      8'h87
`define PVBF_CMD_PRESET7      8'h88
`define PVBF_CMD_USER_REV     8'hf9
`define PVBF_CMD_REC_GEN      8'hfc
`define PVBF_CMD_REC_PH14     8'hfd
`define PVBF_CMD_REC_PH57     8'hfe

// Reset values
`define PVBF_PRESET_RST       16'h0000
`define PVBF_USER_REV_RST     16'h0000
`define PVBF_REC_RST          16'h0000

// Record layout
`define PVBF_GEN_VALID_MASK   16'h3fff
`define PVBF_PH57_VALID_MASK  16'hff0f
`define PVBF_CLEAR_VALUE      16'h0000
`define PVBF_GEN_TEMP_BIT     13
`define PVBF_GEN_LOC_MSB      12
`define PVBF_GEN_LOC_LSB      10

// Select codes
`define PVBF_SEL_PRESET0      3'b000
`define PVBF_SEL_PRESET5      3'b101
`define PVBF_SEL_PRESET6      3'b110
`define PVBF_SEL_PRESET7      3'b111

// Clear wait
`define PVBF_CLEAR_WAIT_MS    5
`define PVBF_REF_CLK_KHZ      40000
`define PVBF_WAIT_CNT_W       18

`endif

// file: logic/pvbf_pkg.sv
// Types of the preset, boot and fault record register bank.
// Assumes the constants header is compiled alongside.
package pvbf_pkg;

  typedef enum logic {
    PVBF_ST_IDLE,
    PVBF_ST_CLEARING
  } pvbf_clr_st_t;

  typedef enum logic [1:0] {
    PVBF_BOOT_LVL_LOW,
    PVBF_BOOT_LVL_MID,
    PVBF_BOOT_LVL_HIGH
  } pvbf_boot_lvl_t;

  // Fault causes seen this cycle; phase 1 is index 0
  typedef struct packed {
    logic            temp_sense_fault;
    logic [2:0]      sense_loc;
    logic            vin_ov;
    logic            vin_uv;
    logic            io_supply;
    logic            stage_otp;
    logic            r1_ov;
    logic            r1_uv;
    logic            r1_oc;
    logic            r2_ov;
    logic            r2_uv;
    logic            r2_oc;
    logic [6:0][3:0] phase_type;
  } pvbf_fault_ev_t;

  typedef struct packed {
    logic [15:0] gen;
    logic [15:0] ph14;
    logic [15:0] ph57;
  } pvbf_records_t;

endpackage

// file: logic/pvbf_regs.sv
// Preset voltage code, boot code, user revision and fault record bank.
// Assumes a command port from the management bus engine, synchronous inputs,
// and a nonvolatile store that saves and restores the three records.
`timescale 1ns/1ps
`include "pvbf_defs.svh"

module pvbf_regs #(
  parameter int CLEAR_WAIT_CYC = `PVBF_CLEAR_WAIT_MS * `PVBF_REF_CLK_KHZ
) (
  // Clock and reset
  input  wire logic                    ref_clk_in,
  input  wire logic                    nrst_in,
  input  wire logic                    clk_en_in,
  // Command port
  input  wire logic [7:0]              cmd_code_in,
  input  wire logic                    cmd_wr_in,
  input  wire logic                    cmd_rd_in,
  input  wire logic [15:0]             cmd_wdata_in,
  output logic [15:0]                  rd_data_out,
  output logic                         rd_valid_out,
  output logic                         clear_busy_out,
  // Preset selection
  input  wire logic                    preset_select_pin_a,
  input  wire logic                    preset_select_pin_b,
  input  wire logic                    preset_select_pin_c,
  input  wire logic [4:0][15:0]        preset_low_in,
  input  wire pvbf_pkg::pvbf_boot_lvl_t boot_level_in,
  output logic [7:0]                   rail1_target_out,
  output logic [7:0]                   rail2_target_out,
  output logic [7:0]                   rail1_boot_out,
  output logic [7:0]                   rail2_boot_out,
  // Fault detection
  input  wire pvbf_pkg::pvbf_fault_ev_t fault_ev_in,
  // Nonvolatile backing
  input  wire logic                    nv_restore_in,
  input  wire pvbf_pkg::pvbf_records_t nv_rec_in,
  output pvbf_pkg::pvbf_records_t      nv_rec_out,
  output logic                         nv_store_req_out
);
  import pvbf_pkg::*;

  typedef struct packed {
    pvbf_clr_st_t                   st;
    logic [`PVBF_WAIT_CNT_W-1:0]    wait_cnt;
    logic [15:0]                    preset5;
    logic [15:0]                    preset6;
    logic [15:0]                    preset7;
    logic [15:0]                    user_rev;
    pvbf_records_t                  rec;
    logic [15:0]                    rd_data;
    logic                           rd_valid;
    logic [7:0]                     r1_tgt;
    logic [7:0]                     r2_tgt;
    logic [7:0]                     r1_boot;
    logic [7:0]                     r2_boot;
    logic                           nv_req;
  } pvbf_state_t;

  localparam logic [`PVBF_WAIT_CNT_W-1:0] WAIT_LAST =
    `PVBF_WAIT_CNT_W'(CLEAR_WAIT_CYC - 1);

  pvbf_state_t s_q;
  pvbf_state_t s_d;
  logic [2:0]  sel_code;

  assign sel_code = {preset_select_pin_a, preset_select_pin_b, preset_select_pin_c};

  // Preset word chosen by a select code
  function automatic logic [15:0] preset_word(input logic [2:0] code,
                                              input pvbf_state_t s,
                                              input logic [4:0][15:0] low);
    case (code)
      `PVBF_SEL_PRESET5: preset_word = s.preset5;
      `PVBF_SEL_PRESET6: preset_word = s.preset6;
      `PVBF_SEL_PRESET7: preset_word = s.preset7;
      default:           preset_word = low[code];
    endcase
  endfunction

  function automatic logic is_record(input logic [7:0] code);
    is_record = (code == `PVBF_CMD_REC_GEN) || (code == `PVBF_CMD_REC_PH14) ||
                (code == `PVBF_CMD_REC_PH57);
  endfunction

  function automatic logic [15:0] read_word(input logic [7:0] code, input pvbf_state_t s);
    case (code)
      `PVBF_CMD_PRESET5:  read_word = s.preset5;
      `PVBF_CMD_PRESET6:  read_word = s.preset6;
      `PVBF_CMD_PRESET7:  read_word = s.preset7;
      `PVBF_CMD_USER_REV: read_word = s.user_rev;
      `PVBF_CMD_REC_GEN:  read_word = s.rec.gen;
      `PVBF_CMD_REC_PH14: read_word = s.rec.ph14;
      `PVBF_CMD_REC_PH57: read_word = s.rec.ph57;
      default:            read_word = 16'h0000;
    endcase
  endfunction

  // New fault causes laid out as record words
  logic [15:0] ev_gen;
  logic [15:0] ev_ph14;
  logic [15:0] ev_ph57;

  assign ev_gen = {2'b00, fault_ev_in.temp_sense_fault, 3'b000,
                   fault_ev_in.vin_ov, fault_ev_in.vin_uv,
                   fault_ev_in.io_supply, fault_ev_in.stage_otp,
                   fault_ev_in.r1_ov, fault_ev_in.r1_uv, fault_ev_in.r1_oc,
                   fault_ev_in.r2_ov, fault_ev_in.r2_uv, fault_ev_in.r2_oc};

  // Phase nibbles: phases 1..4 high to low, then 5, 6, gap, 7
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ph14
      assign ev_ph14[15-4*g -: 4] = fault_ev_in.phase_type[g];
    end
  endgenerate
  assign ev_ph57 = {fault_ev_in.phase_type[4], fault_ev_in.phase_type[5],
                    4'h0, fault_ev_in.phase_type[6]};

  always_comb begin
    logic        clr_gen;
    logic        clr_ph14;
    logic        clr_ph57;
    logic        wr_ok;
    logic [15:0] base;
    logic [15:0] boot_word;
    clr_gen   = 1'b0;
    clr_ph14  = 1'b0;
    clr_ph57  = 1'b0;
    wr_ok     = 1'b0;
    base      = 16'h0000;
    boot_word = 16'h0000;
    s_d       = s_q;
    s_d.nv_req   = 1'b0;
    s_d.rd_valid = 1'b0;

    // Clear wait sequencing; writes are refused while clearing
    case (s_q.st)
      PVBF_ST_IDLE: begin
        wr_ok = cmd_wr_in;
      end
      PVBF_ST_CLEARING: begin
        if (s_q.wait_cnt == WAIT_LAST) begin
          s_d.st       = PVBF_ST_IDLE;
          s_d.wait_cnt = '0;
        end else begin
          s_d.wait_cnt = s_q.wait_cnt + 1'b1;
        end
      end
      default: begin
        s_d.st = PVBF_ST_IDLE;
      end
    endcase

    if (wr_ok) begin
      case (cmd_code_in)
        `PVBF_CMD_PRESET5:  s_d.preset5  = cmd_wdata_in;
        `PVBF_CMD_PRESET6:  s_d.preset6  = cmd_wdata_in;
        `PVBF_CMD_PRESET7:  s_d.preset7  = cmd_wdata_in;
        `PVBF_CMD_USER_REV: s_d.user_rev = cmd_wdata_in;
        default: begin
        end
      endcase
      // Only the clear value acts on a record; other values are dropped
      if (is_record(cmd_code_in) && cmd_wdata_in == `PVBF_CLEAR_VALUE) begin
        clr_gen      = (cmd_code_in == `PVBF_CMD_REC_GEN);
        clr_ph14     = (cmd_code_in == `PVBF_CMD_REC_PH14);
        clr_ph57     = (cmd_code_in == `PVBF_CMD_REC_PH57);
        s_d.st       = PVBF_ST_CLEARING;
        s_d.wait_cnt = '0;
      end
    end

    // Restore from backing, else accumulate; a new cause wins over a clear
    if (nv_restore_in) begin
      s_d.rec.gen  = nv_rec_in.gen  & `PVBF_GEN_VALID_MASK;
      s_d.rec.ph14 = nv_rec_in.ph14;
      s_d.rec.ph57 = nv_rec_in.ph57 & `PVBF_PH57_VALID_MASK;
    end else begin
      base = clr_gen ? `PVBF_REC_RST : s_q.rec.gen;
      s_d.rec.gen = (base | ev_gen) & `PVBF_GEN_VALID_MASK;
      if (fault_ev_in.sense_loc != 3'b000) begin
        s_d.rec.gen[`PVBF_GEN_LOC_MSB:`PVBF_GEN_LOC_LSB] = fault_ev_in.sense_loc;
      end
      s_d.rec.ph14 = (clr_ph14 ? `PVBF_REC_RST : s_q.rec.ph14) | ev_ph14;
      s_d.rec.ph57 = ((clr_ph57 ? `PVBF_REC_RST : s_q.rec.ph57) | ev_ph57)
                     & `PVBF_PH57_VALID_MASK;
    end
    s_d.nv_req = (s_d.rec != s_q.rec) && !nv_restore_in;

    if (cmd_rd_in) begin
      s_d.rd_data  = read_word(cmd_code_in, s_q);
      s_d.rd_valid = 1'b1;
    end

    base       = preset_word(sel_code, s_q, preset_low_in);
    s_d.r1_tgt = base[15:8];
    s_d.r2_tgt = base[7:0];

    case (boot_level_in)
      PVBF_BOOT_LVL_LOW: boot_word = s_q.preset5;
      PVBF_BOOT_LVL_MID: boot_word = s_q.preset6;
      default:           boot_word = s_q.preset7;
    endcase
    s_d.r1_boot = boot_word[15:8];
    s_d.r2_boot = boot_word[7:0];
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q          <= '0;
      s_q.st       <= PVBF_ST_IDLE;
      s_q.preset5  <= `PVBF_PRESET_RST;
      s_q.preset6  <= `PVBF_PRESET_RST;
      s_q.preset7  <= `PVBF_PRESET_RST;
      s_q.user_rev <= `PVBF_USER_REV_RST;
    end else if (clk_en_in) begin
      s_q <= s_d;
    end
  end

  assign rd_data_out      = s_q.rd_data;
  assign rd_valid_out     = s_q.rd_valid;
  assign clear_busy_out   = (s_q.st == PVBF_ST_CLEARING);
  assign rail1_target_out = s_q.r1_tgt;
  assign rail2_target_out = s_q.r2_tgt;
  assign rail1_boot_out   = s_q.r1_boot;
  assign rail2_boot_out   = s_q.r2_boot;
  assign nv_rec_out       = s_q.rec;
  assign nv_store_req_out = s_q.nv_req;

  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  a_tgt_sel_zero: assert property (
    clk_en_in && sel_code == `PVBF_SEL_PRESET0
    |=> {rail1_target_out, rail2_target_out} == $past(preset_low_in[0]))
    else $error("select 000 target mismatch");

  a_tgt_sel_five: assert property (
    clk_en_in && sel_code == `PVBF_SEL_PRESET5
    |=> rail1_target_out == $past(s_q.preset5[15:8]) && rail2_target_out == $past(s_q.preset5[7:0]))
    else $error("select 101 target mismatch");

  a_tgt_sel_six: assert property (
    clk_en_in && sel_code == `PVBF_SEL_PRESET6
    |=> {rail1_target_out, rail2_target_out} == $past(s_q.preset6))
    else $error("select 110 target mismatch");

  a_tgt_sel_seven: assert property (
    clk_en_in && sel_code == `PVBF_SEL_PRESET7
    |=> {rail1_target_out, rail2_target_out} == $past(s_q.preset7))
    else $error("select 111 target mismatch");

  a_boot_mid_level: assert property (
    clk_en_in && boot_level_in == PVBF_BOOT_LVL_MID
    |=> {rail1_boot_out, rail2_boot_out} == $past(s_q.preset6))
    else $error("boot code not from seventh preset");

  a_user_rev_write: assert property (
    clk_en_in && cmd_wr_in && !clear_busy_out && cmd_code_in == `PVBF_CMD_USER_REV
    ##1 clk_en_in && cmd_rd_in && cmd_code_in == `PVBF_CMD_USER_REV
    |=> rd_valid_out && rd_data_out == $past(cmd_wdata_in, 2))
    else $error("user revision readback wrong");

  a_rec_hold_quiet: assert property (
    clk_en_in && !nv_restore_in && fault_ev_in == '0 && !cmd_wr_in
    |=> $stable(nv_rec_out))
    else $error("record changed without cause");

  a_rec_clear_zero: assert property (
    clk_en_in && !clear_busy_out && cmd_wr_in && cmd_code_in == `PVBF_CMD_REC_GEN &&
    cmd_wdata_in == 16'h0000 && fault_ev_in == '0 && !nv_restore_in
    |=> nv_rec_out.gen == 16'h0000 && clear_busy_out)
    else $error("general record not cleared");

  a_reserved_zero: assert property (
    nv_rec_out.gen[15:14] == 2'b00 && nv_rec_out.ph57[7:4] == 4'h0)
    else $error("reserved record bits set");

  a_temp_fault_set: assert property (
    clk_en_in && fault_ev_in.temp_sense_fault && !nv_restore_in
    |=> nv_rec_out.gen[13] ##1 (!clk_en_in || nv_rec_out.gen[13] || $past(cmd_wr_in) || $past(nv_restore_in)))
    else $error("temperature fault bit lost");

  a_sense_loc_load: assert property (
    clk_en_in && fault_ev_in.sense_loc != 3'b000 && !nv_restore_in
    |=> nv_rec_out.gen[12:10] == $past(fault_ev_in.sense_loc))
    else $error("sense fault location wrong");

  a_phase1_nibble: assert property (
    clk_en_in && !nv_restore_in
    |=> (nv_rec_out.ph14[15:12] & $past(fault_ev_in.phase_type[0])) == $past(fault_ev_in.phase_type[0]))
    else $error("phase one fault type lost");

  a_nv_store_req: assert property (
    clk_en_in && !nv_restore_in && fault_ev_in.r1_ov && !nv_rec_out.gen[5]
    |=> nv_store_req_out && nv_rec_out.gen[5])
    else $error("store request missing on new fault");

  a_boot_low_level: assert property (
    clk_en_in && boot_level_in == PVBF_BOOT_LVL_LOW
    |=> {rail1_boot_out, rail2_boot_out} == $past(s_q.preset5))
    else $error("boot code not from sixth preset");

  a_boot_high_level: assert property (
    clk_en_in && boot_level_in != PVBF_BOOT_LVL_LOW && boot_level_in != PVBF_BOOT_LVL_MID
    |=> {rail1_boot_out, rail2_boot_out} == $past(s_q.preset7))
    else $error("boot code not from eighth preset");

  a_ph14_clear_zero: assert property (
    clk_en_in && !clear_busy_out && cmd_wr_in && cmd_code_in == `PVBF_CMD_REC_PH14 &&
    cmd_wdata_in == 16'h0000 && fault_ev_in == '0 && !nv_restore_in
    |=> nv_rec_out.ph14 == 16'h0000 && clear_busy_out)
    else $error("phase one to four record not cleared");

  a_rec_write_drop: assert property (
    clk_en_in && cmd_wr_in && is_record(cmd_code_in) && cmd_wdata_in != 16'h0000 &&
    fault_ev_in == '0 && !nv_restore_in
    |=> $stable(nv_rec_out))
    else $error("record changed by a nonzero write");

  a_input_flags_set: assert property (
    clk_en_in && !nv_restore_in
    |=> &(nv_rec_out.gen[9:7] | ~$past({fault_ev_in.vin_ov, fault_ev_in.vin_uv, fault_ev_in.io_supply})))
    else $error("input fault flag lost");

  a_stage_otp_set: assert property (
    clk_en_in && !nv_restore_in
    |=> nv_rec_out.gen[6] || !$past(fault_ev_in.stage_otp))
    else $error("power stage temperature flag lost");

  a_rail1_flags_set: assert property (
    clk_en_in && !nv_restore_in
    |=> &(nv_rec_out.gen[5:3] | ~$past({fault_ev_in.r1_ov, fault_ev_in.r1_uv, fault_ev_in.r1_oc})))
    else $error("rail one fault flag lost");

  a_rail2_flags_set: assert property (
    clk_en_in && !nv_restore_in
    |=> &(nv_rec_out.gen[2:0] | ~$past({fault_ev_in.r2_ov, fault_ev_in.r2_uv, fault_ev_in.r2_oc})))
    else $error("rail two fault flag lost");

  a_ph57_nibbles_kept: assert property (
    clk_en_in && !nv_restore_in
    |=> &({nv_rec_out.ph57[15:8], nv_rec_out.ph57[3:0]} |
          ~$past({fault_ev_in.phase_type[4], fault_ev_in.phase_type[5], fault_ev_in.phase_type[6]})))
    else $error("phase five to seven fault type lost");

  a_restore_load: assert property (
    clk_en_in && nv_restore_in
    |=> nv_rec_out == ($past(nv_rec_in) & {`PVBF_GEN_VALID_MASK, 16'hffff, `PVBF_PH57_VALID_MASK}))
    else $error("restored records wrong");

endmodule // pvbf_regs

// file: verif/pvbf_host.sv
// Host management controller model driving the bank's command port.
// Assumes the bench owns the clock and calls the tasks from one process.
`timescale 1ns/1ps
module pvbf_host (
  // Clock and status
  input  wire logic        clk_in,
  input  wire logic        busy_in,
  input  wire logic        rd_valid_in,
  input  wire logic [15:0] rd_data_in,
  // Command port
  output logic [7:0]       code_out,
  output logic             wr_out,
  output logic             rd_out,
  output logic [15:0]      wdata_out
);
  initial begin
    code_out  = 8'h00;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
    wdata_out = 16'h0000;
  end
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk_in);
    code_out  <= c;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    wdata_out <= ~d;
  endtask
  task automatic rd(input logic [7:0] c, output logic v, output logic [15:0] d);
    @(posedge clk_in);
    code_out <= c;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out   <= 1'b0;
    #1;
    v = rd_valid_in;
    d = rd_data_in;
  endtask
  // Write, then a read of the same word taken on the very next edge
  task automatic wrrd(input logic [7:0] c, input logic [15:0] d, output logic v, output logic [15:0] q);
    wr(c, d);
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    #1;
    v = rd_valid_in;
    q = rd_data_in;
  endtask
  // Writes the clear value, then stays off the bus until busy drops or 100000 edges pass
  task automatic clr(input logic [7:0] c, output int n);
    wr(c, 16'h0000);
    #1;
    n = 0;
    while (busy_in === 1'b1 && n < 100000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
  endtask
endmodule // pvbf_host

// file: verif/tb.sv
// Self-checking bench for the preset, boot and fault record bank.
// Assumes the host model drives the command port; the bench drives pins and faults.
`timescale 1ns/1ps
`include "pvbf_defs.svh"
module tb;
  import pvbf_pkg::*;
  localparam int CW = 20;
  logic                 clk, nrst, clk_en, busy, rdv, wr, rd, restore, store, pa, pb, pc;
  logic [7:0]           code, r1t, r2t, r1b, r2b;
  logic                 rv;
  logic [15:0]          wdata, rdata, rw;
  logic [4:0][15:0]     low;
  logic [15:0]          pre [9];
  logic [3:0]           codes [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
  logic [7:0]           cmds [8];
  pvbf_boot_lvl_t       boot;
  pvbf_fault_ev_t       ev, e;
  pvbf_records_t        nvi, nvo, x;
  int                   n_fail, n_tests, cyc, k;

  pvbf_regs #(.CLEAR_WAIT_CYC(CW)) pvbf_regs_i (
    .ref_clk_in(clk), .nrst_in(nrst), .clk_en_in(clk_en), .cmd_code_in(code), .cmd_wr_in(wr),
    .cmd_rd_in(rd), .cmd_wdata_in(wdata), .rd_data_out(rdata), .rd_valid_out(rdv),
    .clear_busy_out(busy), .preset_select_pin_a(pa), .preset_select_pin_b(pb),
    .preset_select_pin_c(pc), .preset_low_in(low), .boot_level_in(boot), .rail1_target_out(r1t),
    .rail2_target_out(r2t), .rail1_boot_out(r1b), .rail2_boot_out(r2b), .fault_ev_in(ev),
    .nv_restore_in(restore), .nv_rec_in(nvi), .nv_rec_out(nvo), .nv_store_req_out(store));
  pvbf_host pvbf_host_i (
    .clk_in(clk), .busy_in(busy), .rd_valid_in(rdv), .rd_data_in(rdata),
    .code_out(code), .wr_out(wr), .rd_out(rd), .wdata_out(wdata));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] c, input logic [15:0] x);
    logic        v;
    logic [15:0] d;
    pvbf_host_i.rd(c, v, d);
    chk({47'h0, v}, 48'h1);
    chk({32'h0, d}, {32'h0, x});
  endtask
  function automatic pvbf_records_t exp_rec(input pvbf_fault_ev_t f);
    pvbf_records_t r;
    r.gen  = {2'b00, f.temp_sense_fault, f.sense_loc, f.vin_ov, f.vin_uv, f.io_supply, f.stage_otp,
              f.r1_ov, f.r1_uv, f.r1_oc, f.r2_ov, f.r2_uv, f.r2_oc};
    r.ph14 = {f.phase_type[0], f.phase_type[1], f.phase_type[2], f.phase_type[3]};
    r.ph57 = {f.phase_type[4], f.phase_type[5], 4'h0, f.phase_type[6]};
    return r;
  endfunction
  // Boot level 3 falls back to the highest preset
  function automatic int bsel(input int i);
    return (i % 4 == 3) ? 2 : i % 4;
  endfunction

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    n_fail = 0;
    n_tests = 0;
    void'($urandom(30734));
    nrst = 1'b0;
    clk_en = 1'b1;
    {pa, pb, pc} = 3'b000;
    boot = PVBF_BOOT_LVL_LOW;
    ev = '0;
    restore = 1'b0;
    nvi = '0;
    cmds = '{`PVBF_CMD_PRESET5, `PVBF_CMD_PRESET6, `PVBF_CMD_PRESET7, `PVBF_CMD_USER_REV,
             `PVBF_CMD_REC_GEN, `PVBF_CMD_REC_PH14, `PVBF_CMD_REC_PH57, 8'h00};
    for (int i = 0; i < 5; i++) begin
      low[i] = 16'($urandom());
      pre[i] = low[i];
    end
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++)
      rdc(cmds[i], 16'h0000);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      pre[5 + i] = 16'($urandom());
      pvbf_host_i.wr(cmds[i], pre[5 + i]);
    end
    for (int i = 0; i < 4; i++)
      rdc(cmds[i], pre[5 + i]);
    pre[8] = 16'($urandom());
    pvbf_host_i.wrrd(cmds[3], pre[8], rv, rw);
    chk({47'h0, rv}, 48'h1);
    chk({32'h0, rw}, {32'h0, pre[8]});
    $display("test preset and revision words done");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      {pa, pb, pc} <= 3'(i);
      boot <= pvbf_boot_lvl_t'(i[1:0]);
      @(posedge clk);
      #1;
      chk({32'h0, r1t, r2t}, {32'h0, pre[i]});
      chk({32'h0, r1b, r2b}, {32'h0, pre[5 + bsel(i)]});
    end
    $display("test target and boot codes done");
    for (int n = 0; n < 8; n++) begin
      for (int j = 4; j < 7; j++) begin
        pvbf_host_i.clr(cmds[j], k);
        chk(48'(k), 48'(CW));
      end
      e = pvbf_fault_ev_t'(42'({$urandom(), $urandom()}));
      e.sense_loc = 3'(n);
      for (int p = 0; p < 7; p++)
        e.phase_type[p] = codes[$urandom_range(4)];
      x = exp_rec(e);
      @(posedge clk);
      ev <= e;
      @(posedge clk);
      ev <= '0;
      #1;
      chk(nvo, x);
      chk({47'h0, store}, {47'h0, |x});
      @(posedge clk);
      #1;
      chk({47'h0, store}, 48'h0);
      rdc(cmds[4], x.gen);
      rdc(cmds[5], x.ph14);
      rdc(cmds[6], x.ph57);
    end
    $display("test fault records done");
    // Frozen clock enable must keep the records through a burst of faults
    @(posedge clk);
    clk_en <= 1'b0;
    ev <= '1;
    repeat (2) @(posedge clk);
    clk_en <= 1'b1;
    ev <= '0;
    #1;
    chk(nvo, x);
    @(posedge clk);
    nvi <= '1;
    restore <= 1'b1;
    @(posedge clk);
    restore <= 1'b0;
    nvi <= '0;
    #1;
    chk(nvo, {16'h3fff, 16'hffff, 16'hff0f});
    pvbf_host_i.wr(cmds[4], 16'hffff);
    pvbf_host_i.wr(cmds[6], 16'h00f0);
    rdc(cmds[4], 16'h3fff);
    rdc(cmds[6], 16'hff0f);
    $display("test restore and reserved bits done");
    give_verdict();
  end
endmodule // tb
